// ### spb_pkg.sv
// Purpose: shared constants and types for the serial packetizer bridge
// Assumes: 125 MHz system clock, one clock domain
// Notes: all timing counts derive from the clock rate below
`default_nettype none

package spb_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned BAUD_MIN = 300;
    localparam logic [3:0] BAUD_SEL_RST = 4'h5;
    localparam logic [3:0] BAUD_SEL_MAX = 4'hb;
    localparam int unsigned DIR_MS_MAX = 9999;
    localparam logic [13:0] DIR_MS_RST = 14'h0000;
    localparam logic [15:0] BUF_MS_RST = 16'h01f4;
    localparam logic [10:0] PKT_LEN_MAX = 11'h400;
    localparam logic [10:0] PKT_LEN_RST = 11'h000;
    localparam logic [7:0] TERM_RST = 8'h00;
    localparam logic [7:0] XON_CHAR = 8'h11;
    localparam logic [7:0] XOFF_CHAR = 8'h13;
    localparam logic [2:0] SESS_MAX_RST = 3'h5;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned FIFO_ROOM = 2;

    typedef enum logic [1:0] {SPB_PAR_NONE = 2'h0, SPB_PAR_EVEN = 2'h1,
        SPB_PAR_ODD = 2'h2} spb_par_t;
    typedef enum logic [1:0] {SPB_FLOW_NONE = 2'h0, SPB_FLOW_HW = 2'h1,
        SPB_FLOW_SW = 2'h2} spb_flow_t;
    typedef enum logic [2:0] {SPB_CC_NONE = 3'h0, SPB_CC_RTS_UP = 3'h1,
        SPB_CC_RTS_DN = 3'h2, SPB_CC_DTR_UP = 3'h3, SPB_CC_DTR_DN = 3'h4} spb_conn_t;
    // disconnect: bit2..1 line (0 none,1 dsr,2 cts,3 dcd), bit0 1=rise
    typedef enum logic [2:0] {SPB_TX_IDLE = 3'h0, SPB_TX_START = 3'h1,
        SPB_TX_DATA = 3'h3, SPB_TX_PAR = 3'h2, SPB_TX_STOP = 3'h6} spb_txst_t;
    typedef enum logic [2:0] {SPB_RX_IDLE = 3'h0, SPB_RX_START = 3'h1,
        SPB_RX_DATA = 3'h3, SPB_RX_PAR = 3'h2, SPB_RX_STOP = 3'h6} spb_rxst_t;

    function automatic logic [19:0] spb_bit_cycles(input logic [3:0] sel);
        logic [31:0] rate;
        rate = 32'(BAUD_MIN);
        // 300..38400 double; then 57600, 115200, 230400, 460800
        if (sel <= 4'h7) begin
            rate = rate << sel;
        end else begin
            rate = 32'd57600 << (sel - 4'h8);
        end
        return 20'(CLK_HZ / rate);
    endfunction
endpackage

`default_nettype wire

// ### spb_fifo_if.sv
// Purpose: stream carrier between the packetizer and its byte buffer
// Assumes: one clock domain
// Notes: valid/ready handshake on both sides
`default_nettype none

interface spb_fifo_if #(parameter int W = 9);
    logic [W-1:0] wr_data;
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] rd_data;
    logic rd_valid;
    logic rd_ready;
    logic [3:0] level;
    modport owner (output wr_data, wr_valid, rd_ready,
        input wr_ready, rd_data, rd_valid, level);
    modport buffer (input wr_data, wr_valid, rd_ready,
        output wr_ready, rd_data, rd_valid, level);
endinterface

`default_nettype wire

// ### spb_fifo.sv
// Purpose: byte buffer on the serial-to-network path
// Assumes: depth is a power of two, at most 8 for the level port
// Notes: read data come from a register; full and empty are exact
`default_nettype none

module spb_fifo
    import spb_pkg::*;
#(
    parameter int W = 9,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    spb_fifo_if.buffer f
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wp_q, rp_q;
    logic [W-1:0] rd_q;
    logic rdv_q;
    logic full, empty, push, pop, load;

    assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty = (wp_q == rp_q);
    assign push = f.wr_valid && !full;
    // output register refills when empty or being taken
    assign load = !empty && (!rdv_q || f.rd_ready);
    assign pop = load;
    assign f.wr_ready = !full;
    assign f.rd_data = rd_q;
    assign f.rd_valid = rdv_q;
    assign f.level = 4'(wp_q - rp_q) + {3'h0, rdv_q};

    always_ff @(posedge i_mclk) begin
        if (i_ce && push) begin
            mem[wp_q[AW-1:0]] <= f.wr_data;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            rdv_q <= 1'b0;
            rd_q <= '0;
        end else if (i_ce) begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
                rd_q <= mem[rp_q[AW-1:0]];
                rdv_q <= 1'b1;
            end else if (f.rd_ready) begin
                rdv_q <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// ### spb_bridge.sv
// Purpose: serial port front end of a serial-to-network bridge
// Assumes: network session logic outside; pins are synchronous to nothing
// Notes: a flush flag, held until the next buffered byte, marks the last byte of a packet on the net side
`default_nettype none

module spb_bridge
    import spb_pkg::*;
#(
    parameter int unsigned CYC_PER_SEC = CLK_HZ
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [3:0] i_baud_sel,
    input wire logic i_eight_bits,
    input wire logic [1:0] i_parity,
    input wire logic i_two_stop,
    input wire logic [1:0] i_flow,
    input wire logic i_four_wire,
    input wire logic [13:0] i_dir_ms,
    input wire logic [2:0] i_conn_ctl,
    input wire logic [7:0] i_term_char,
    input wire logic i_fwd_term,
    input wire logic [15:0] i_buf_ms,
    input wire logic [10:0] i_pkt_len,
    input wire logic [15:0] i_idle_sec,
    input wire logic [2:0] i_disc_sel,
    input wire logic [2:0] i_sess_max,
    input wire logic i_rxd,
    input wire logic i_cts,
    input wire logic i_dsr,
    input wire logic i_dcd,
    input wire logic i_sess_open,
    input wire logic [2:0] i_sess_id,
    input wire logic [2:0] i_sess_count,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    input wire logic i_net_ready,
    output logic o_txd,
    output logic o_rts,
    output logic o_dtr,
    output logic o_de,
    output logic o_re_n,
    output logic o_tx_ready,
    output logic [7:0] o_net_data,
    output logic o_net_valid,
    output logic o_net_last,
    output logic o_rx_err,
    output logic o_pass,
    output logic o_teardown
);
    // three-stage input synchronisers: s1 feeds s2 only
    logic [3:0] s1_q, s2_q, s3_q;
    logic rxd_s, cts_s, dsr_s, dcd_s;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s1_q <= 4'hf;
            s2_q <= 4'hf;
            s3_q <= 4'hf;
        end else if (i_ce) begin
            s1_q <= {i_dcd, i_dsr, i_cts, i_rxd};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // a change counts once stages two and three agree
    logic [3:0] pin_q;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pin_q <= 4'hf;
        end else if (i_ce) begin
            for (int k = 0; k < 4; k++) begin
                if (s2_q[k] == s3_q[k]) begin
                    pin_q[k] <= s3_q[k];
                end
            end
        end
    end
    assign rxd_s = pin_q[0];
    assign cts_s = pin_q[1];
    assign dsr_s = pin_q[2];
    assign dcd_s = pin_q[3];

    logic [19:0] bit_cyc;
    assign bit_cyc = spb_bit_cycles((i_baud_sel > BAUD_SEL_MAX) ? BAUD_SEL_RST : i_baud_sel);
    logic [3:0] nbits;
    assign nbits = i_eight_bits ? 4'h8 : 4'h7;

    function automatic logic par_of(input logic [7:0] d, input logic eight, input logic [1:0] p);
        logic x;
        x = ^(eight ? d : {1'b0, d[6:0]});
        return (p == SPB_PAR_ODD) ? ~x : x;
    endfunction

    // receiver and flow state
    logic xoff_q, rx_busy;
    logic [7:0] rx_byte;
    logic rx_stb;

    // ---------------- transmitter ----------------
    spb_txst_t tx_st_q;
    logic [19:0] tx_cnt_q;
    logic [3:0] tx_bit_q;
    logic [7:0] tx_sh_q;
    logic tx_par_q;
    logic dir_ok, owner_ok, tx_go;
    // only session zero may write; readers only observe
    assign owner_ok = (i_sess_id == 3'h0) && (i_sess_count <= i_sess_max) && (i_sess_max != 3'h0);
    // hardware CTS or received XOFF holds transmit
    assign tx_go = !(i_flow == SPB_FLOW_HW && cts_s) && !(i_flow == SPB_FLOW_SW && xoff_q);
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            tx_st_q <= SPB_TX_IDLE;
            tx_cnt_q <= '0;
            tx_bit_q <= '0;
            tx_sh_q <= '0;
            tx_par_q <= 1'b0;
            o_txd <= 1'b1;
            o_tx_ready <= 1'b0;
        end else if (i_ce) begin
            o_tx_ready <= 1'b0;
            if (tx_st_q != SPB_TX_IDLE) begin
                tx_cnt_q <= (tx_cnt_q == 20'h1) ? bit_cyc : tx_cnt_q - 20'h1;
            end
            case (tx_st_q)
                SPB_TX_IDLE: begin
                    o_txd <= 1'b1;
                    // traffic waits until the session line has been set
                    if (i_tx_valid && owner_ok && o_pass && tx_go && dir_ok && !o_tx_ready) begin
                        o_tx_ready <= 1'b1;
                        tx_sh_q <= i_tx_data;
                        tx_par_q <= par_of(i_tx_data, i_eight_bits, i_parity);
                        tx_cnt_q <= bit_cyc;
                        o_txd <= 1'b0;
                        tx_st_q <= SPB_TX_START;
                    end
                end
                SPB_TX_START: if (tx_cnt_q == 20'h1) begin
                    o_txd <= tx_sh_q[0];
                    tx_sh_q <= tx_sh_q >> 1;
                    tx_bit_q <= 4'h1;
                    tx_st_q <= SPB_TX_DATA;
                end
                SPB_TX_DATA: if (tx_cnt_q == 20'h1) begin
                    if (tx_bit_q != nbits) begin
                        o_txd <= tx_sh_q[0];
                        tx_sh_q <= tx_sh_q >> 1;
                        tx_bit_q <= tx_bit_q + 4'h1;
                    end else if (i_parity != SPB_PAR_NONE) begin
                        o_txd <= tx_par_q;
                        tx_st_q <= SPB_TX_PAR;
                    end else begin
                        o_txd <= 1'b1;
                        tx_bit_q <= 4'h0;
                        tx_st_q <= SPB_TX_STOP;
                    end
                end
                SPB_TX_PAR: if (tx_cnt_q == 20'h1) begin
                    o_txd <= 1'b1;
                    tx_bit_q <= 4'h0;
                    tx_st_q <= SPB_TX_STOP;
                end
                SPB_TX_STOP: if (tx_cnt_q == 20'h1) begin
                    if (i_two_stop && tx_bit_q == 4'h0) begin
                        tx_bit_q <= 4'h1;
                    end else begin
                        tx_st_q <= SPB_TX_IDLE;
                    end
                end
                default: tx_st_q <= SPB_TX_IDLE;
            endcase
        end
    end

    // ---------------- RS-485 direction ----------------
    logic [13:0] dir_ms_q;
    logic [16:0] ms_cnt_q;
    logic tx_act;
    assign tx_act = (tx_st_q != SPB_TX_IDLE);
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            dir_ms_q <= '0;
            ms_cnt_q <= '0;
            o_de <= 1'b0;
            o_re_n <= 1'b0;
        end else if (i_ce) begin
            if (i_four_wire) begin
                // four-wire: both directions always on, timer ignored
                o_de <= 1'b1;
                o_re_n <= 1'b0;
                dir_ms_q <= '0;
            end else if (tx_act || o_tx_ready) begin
                o_de <= 1'b1;
                o_re_n <= 1'b1;
                dir_ms_q <= i_dir_ms;
                ms_cnt_q <= 17'(CYC_PER_MS);
            end else if (dir_ms_q != '0) begin
                // hold transmit direction for the turnaround interval
                ms_cnt_q <= ms_cnt_q - 17'h1;
                if (ms_cnt_q == 17'h1) begin
                    ms_cnt_q <= 17'(CYC_PER_MS);
                    dir_ms_q <= dir_ms_q - 14'h1;
                end
            end else begin
                o_de <= 1'b0;
                o_re_n <= 1'b0;
            end
        end
    end
    // two-wire: no new transmit while receiving a character
    assign dir_ok = i_four_wire || !rx_busy;

    // ---------------- receiver ----------------
    spb_rxst_t rx_st_q;
    logic [19:0] rx_cnt_q;
    logic [3:0] rx_bit_q;
    logic [7:0] rx_sh_q;
    logic rx_stb_q, rx_err_q;
    assign rx_busy = (rx_st_q != SPB_RX_IDLE);
    assign rx_byte = rx_sh_q;
    assign rx_stb = rx_stb_q;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rx_st_q <= SPB_RX_IDLE;
            rx_cnt_q <= '0;
            rx_bit_q <= '0;
            rx_sh_q <= '0;
            rx_stb_q <= 1'b0;
            rx_err_q <= 1'b0;
        end else if (i_ce) begin
            rx_stb_q <= 1'b0;
            rx_cnt_q <= rx_cnt_q - 20'h1;
            case (rx_st_q)
                SPB_RX_IDLE: if (!rxd_s) begin
                    rx_cnt_q <= {1'b0, bit_cyc[19:1]};
                    rx_st_q <= SPB_RX_START;
                end
                SPB_RX_START: if (rx_cnt_q == 20'h0) begin
                    rx_err_q <= 1'b0;
                    rx_cnt_q <= bit_cyc - 20'h1;
                    rx_bit_q <= 4'h0;
                    rx_sh_q <= '0;
                    rx_st_q <= rxd_s ? SPB_RX_IDLE : SPB_RX_DATA;
                end
                SPB_RX_DATA: if (rx_cnt_q == 20'h0) begin
                    rx_cnt_q <= bit_cyc - 20'h1;
                    rx_sh_q[rx_bit_q[2:0]] <= rxd_s;
                    rx_bit_q <= rx_bit_q + 4'h1;
                    if (rx_bit_q + 4'h1 == nbits) begin
                        rx_st_q <= (i_parity != SPB_PAR_NONE) ? SPB_RX_PAR : SPB_RX_STOP;
                    end
                end
                SPB_RX_PAR: if (rx_cnt_q == 20'h0) begin
                    rx_cnt_q <= bit_cyc - 20'h1;
                    rx_err_q <= (rxd_s != par_of(rx_sh_q, i_eight_bits, i_parity));
                    rx_st_q <= SPB_RX_STOP;
                end
                SPB_RX_STOP: if (rx_cnt_q == 20'h0) begin
                    if (!rxd_s) begin
                        rx_err_q <= 1'b1;
                    end else begin
                        rx_stb_q <= 1'b1;
                    end
                    rx_st_q <= SPB_RX_IDLE;
                end
                default: rx_st_q <= SPB_RX_IDLE;
            endcase
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_rx_err <= 1'b0;
        end else if (i_ce) begin
            o_rx_err <= rx_err_q;
        end
    end

    // ---------------- packetizer ----------------
    spb_fifo_if #(.W(9)) fq ();
    spb_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .f(fq)
    );
    logic is_term, is_flow, keep;
    logic [10:0] cnt_q;
    logic [15:0] bms_q;
    logic [16:0] bcy_q;
    logic flush_q, near_full;
    assign is_term = (i_term_char != TERM_RST) && (rx_byte == i_term_char);
    assign is_flow = (i_flow == SPB_FLOW_SW) && (rx_byte == XON_CHAR || rx_byte == XOFF_CHAR);
    // keep drops the terminator when forwarding is off; wr_valid still writes it
    assign keep = rx_stb && !is_flow && (!is_term || i_fwd_term);
    // leave room for bytes still arriving
    assign near_full = (fq.level >= 4'(FIFO_DEPTH - FIFO_ROOM));
    assign fq.wr_valid = keep || (rx_stb && is_term && !i_fwd_term);
    // bit 8 marks the final byte of a packet; a terminator is written with bit 8 set even when forwarding is off
    assign fq.wr_data = {is_term || (i_pkt_len != PKT_LEN_RST && cnt_q + 11'h1 >= i_pkt_len)
        || near_full || flush_q, rx_byte};
    assign fq.rd_ready = !o_net_valid || i_net_ready;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            xoff_q <= 1'b0;
        end else if (i_ce && rx_stb && i_flow == SPB_FLOW_SW) begin
            if (rx_byte == XOFF_CHAR) begin
                xoff_q <= 1'b1;
            end else if (rx_byte == XON_CHAR) begin
                xoff_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cnt_q <= '0;
            bms_q <= '0;
            bcy_q <= '0;
            flush_q <= 1'b0;
        end else if (i_ce) begin
            if (fq.wr_valid && fq.wr_ready) begin
                cnt_q <= fq.wr_data[8] ? 11'h0 : cnt_q + 11'h1;
                flush_q <= 1'b0;
                if (cnt_q == 11'h0) begin
                    bms_q <= i_buf_ms;
                    bcy_q <= 17'(CYC_PER_MS);
                end
            end else if (cnt_q != 11'h0 && !flush_q) begin
                // buffering interval expiry forces the next byte to end a packet
                if (bcy_q == 17'h1) begin
                    bcy_q <= 17'(CYC_PER_MS);
                    if (bms_q <= 16'h1) begin
                        flush_q <= 1'b1;
                    end else begin
                        bms_q <= bms_q - 16'h1;
                    end
                end else begin
                    bcy_q <= bcy_q - 17'h1;
                end
            end
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_net_data <= '0;
            o_net_valid <= 1'b0;
            o_net_last <= 1'b0;
        end else if (i_ce && fq.rd_ready) begin
            o_net_valid <= fq.rd_valid;
            o_net_data <= fq.rd_data[7:0];
            o_net_last <= fq.rd_valid && (fq.rd_data[8] || (flush_q && fq.level == 4'h1));
        end
    end

    // ---------------- session control and teardown ----------------
    logic [26:0] sec_cyc_q;
    logic [15:0] idle_q;
    logic [2:0] edge_prev_q;
    logic disc_hit, line_now, line_prev;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_rts <= 1'b1;
            o_dtr <= 1'b1;
            o_pass <= 1'b0;
        end else if (i_ce) begin
            o_pass <= i_sess_open;
            // session open sets the selected line before traffic passes
            if (!i_sess_open) begin
                o_pass <= 1'b0;
            end else begin
                case (i_conn_ctl)
                    SPB_CC_RTS_UP: o_rts <= 1'b1;
                    SPB_CC_RTS_DN: o_rts <= 1'b0;
                    SPB_CC_DTR_UP: o_dtr <= 1'b1;
                    SPB_CC_DTR_DN: o_dtr <= 1'b0;
                    default: ;
                endcase
            end
            // hardware flow: deassert RTS when buffer nearly full
            if (i_flow == SPB_FLOW_HW && i_conn_ctl != SPB_CC_RTS_UP
                && i_conn_ctl != SPB_CC_RTS_DN) begin
                o_rts <= near_full;
            end
        end
    end
    always_comb begin
        case (i_disc_sel[2:1])
            2'h1: begin line_now = dsr_s; line_prev = edge_prev_q[0]; end
            2'h2: begin line_now = cts_s; line_prev = edge_prev_q[1]; end
            2'h3: begin line_now = dcd_s; line_prev = edge_prev_q[2]; end
            default: begin line_now = 1'b0; line_prev = 1'b0; end
        endcase
    end
    // selected edge of a modem line
    assign disc_hit = (i_disc_sel[2:1] != 2'h0) && (line_now != line_prev)
        && (line_now == i_disc_sel[0]);
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            edge_prev_q <= 3'h7;
            sec_cyc_q <= '0;
            idle_q <= '0;
            o_teardown <= 1'b0;
        end else if (i_ce) begin
            edge_prev_q <= {dcd_s, cts_s, dsr_s};
            o_teardown <= 1'b0;
            if (!i_sess_open || rx_stb || o_tx_ready) begin
                idle_q <= '0;
                sec_cyc_q <= '0;
            end else if (i_idle_sec != 16'h0) begin
                if (sec_cyc_q == 27'(CYC_PER_SEC - 1)) begin
                    sec_cyc_q <= '0;
                    idle_q <= idle_q + 16'h1;
                    if (idle_q + 16'h1 == i_idle_sec) begin
                        o_teardown <= 1'b1;
                    end
                end else begin
                    sec_cyc_q <= sec_cyc_q + 27'h1;
                end
            end
            if (i_sess_open && disc_hit) begin
                o_teardown <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ### spb_bridge_assertions.sv
// Purpose: port checks for the serial packetizer bridge
// Assumes: i_ce held high by the bench
// Notes: bound to every spb_bridge instance below
`default_nettype none
module spb_bridge_chk (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_tx_valid,
    input wire logic [2:0] i_sess_id,
    input wire logic i_sess_open,
    input wire logic i_net_ready,
    input wire logic o_txd,
    input wire logic o_rts,
    input wire logic o_dtr,
    input wire logic o_tx_ready,
    input wire logic [7:0] o_net_data,
    input wire logic o_net_valid,
    input wire logic o_net_last,
    input wire logic o_pass,
    input wire logic o_teardown,
    input wire logic i_four_wire,
    input wire logic o_de,
    input wire logic o_re_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sequence s_stall; o_net_valid && !i_net_ready; endsequence
    property p_rst; $fell(i_rst) |-> o_txd && o_rts && o_dtr && !o_pass; endproperty
    a_rst: assert property (p_rst) else $error("reset levels");
    property p_start; o_tx_ready |-> !o_txd; endproperty
    a_start: assert property (p_start) else $error("start bit");
    property p_gap; o_tx_ready |=> !o_tx_ready [*8]; endproperty
    a_gap: assert property (p_gap) else $error("byte gap");
    property p_own;
        o_tx_ready |-> $past(i_tx_valid) && $past(i_sess_id) == 3'h0 && $past(o_pass);
    endproperty
    a_own: assert property (p_own) else $error("writer");
    property p_pass; 1'b1 |=> o_pass == $past(i_sess_open); endproperty
    a_pass: assert property (p_pass) else $error("pass");
    property p_last; o_net_last |-> o_net_valid; endproperty
    a_last: assert property (p_last) else $error("last");
    property p_hold; s_stall |=> o_net_valid && $stable(o_net_data) && $stable(o_net_last); endproperty
    a_hold: assert property (p_hold) else $error("stall");
    property p_td; o_teardown |=> !o_teardown; endproperty
    a_td: assert property (p_td) else $error("teardown");
    property p_de; o_tx_ready |-> ##2 o_de && (o_re_n != i_four_wire); endproperty
    a_de: assert property (p_de) else $error("line direction");
endmodule
bind spb_bridge spb_bridge_chk u_chk (.*);
`default_nettype wire

// ### spb_serial_dev.sv
// Purpose: attached serial device model
// Assumes: 8 data bits, no parity, one stop
// Notes: bit time given in clocks
`default_nettype none
module spb_serial_dev #(parameter int BC = 271) (
    input wire logic i_mclk,
    input wire logic i_txd,
    input wire logic i_go,
    input wire logic [7:0] i_byte,
    output logic o_rxd,
    output logic [7:0] o_got
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] f;
    initial begin
        o_rxd = 1'b1;
        forever begin
            @(posedge i_mclk iff i_go);
            f = {1'b1, i_byte, 1'b0};
            for (int i = 0; i < 10; i++) begin
                o_rxd = f[i];
                repeat (BC) @(posedge i_mclk);
            end
        end
    end
    initial begin
        o_got = 8'h00;
        forever begin
            @(negedge i_txd);
            repeat (BC / 2) @(posedge i_mclk);
            for (int i = 0; i < 8; i++) begin
                repeat (BC) @(posedge i_mclk);
                o_got[i] = i_txd;
            end
            repeat (BC) @(posedge i_mclk);
        end
    end
endmodule
`default_nettype wire

// ### spb_bridge_tb_top.sv
// Purpose: self-checking bench for spb_bridge
// Assumes: fastest rate, 8N1, fixed seed
// Notes: one second shortened to 1000 clocks
`default_nettype none
module spb_bridge_tb_top
    import spb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BC = CLK_HZ / 460800;
    logic i_mclk, i_rst, i_ce, i_eight_bits, i_two_stop, i_four_wire, i_fwd_term, i_rxd;
    logic i_cts, i_dsr, i_dcd, i_sess_open, i_tx_valid, i_net_ready, o_txd, o_rts, o_dtr;
    logic o_de, o_re_n, o_tx_ready, o_net_valid, o_net_last, o_rx_err, o_pass, o_teardown, go;
    logic [3:0] i_baud_sel;
    logic [1:0] i_parity, i_flow;
    logic [13:0] i_dir_ms;
    logic [2:0] i_conn_ctl, i_disc_sel, i_sess_max, i_sess_id, i_sess_count;
    logic [7:0] i_term_char, i_tx_data, o_net_data, b, got, s[$];
    logic [15:0] i_buf_ms, i_idle_sec;
    logic [10:0] i_pkt_len;
    logic [31:0] lf;
    logic [8:0] q[$];
    int num_errors, n_checks;
    spb_bridge #(.CYC_PER_SEC(1000)) uut (.*);
    spb_serial_dev #(.BC(BC)) dev (.i_mclk(i_mclk), .i_txd(o_txd), .i_go(go), .i_byte(b),
        .o_rxd(i_rxd), .o_got(got));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [8:0] exp_q(input logic [7:0] d, input int k, input int n);
        return {k == n - 1, d};
    endfunction
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tx_byte(input logic [7:0] d, input logic own);
        i_sess_id = own ? 3'h0 : 3'h1;
        i_tx_data = d;
        i_tx_valid = 1'b1;
        for (int k = 0; k < 6; k++) if (!o_tx_ready) @(negedge i_mclk);
        chk(9'(o_tx_ready), 9'(own));
        i_tx_valid = 1'b0;
        repeat (11 * BC) @(negedge i_mclk);
        if (own) chk({1'b0, got}, {1'b0, d});
    endtask
    task automatic rx_byte(input logic [7:0] d);
        b = d;
        s.push_back(d);
        go = 1'b1;
        @(negedge i_mclk);
        go = 1'b0;
        repeat (11 * BC) @(negedge i_mclk);
    endtask
    task automatic pkt(input int n);
        repeat (30) @(negedge i_mclk);
        chk(9'(q.size()), 9'(n));
        foreach (q[k]) chk(q[k], exp_q(s[k], k, n));
        chk(9'(o_rx_err), 9'h000);
        q.delete();
        s.delete();
    endtask
    task automatic wait_td(input int n);
        // step past any pulse still standing from an earlier trigger
        @(negedge i_mclk);
        for (int k = 0; k < n; k++) if (!o_teardown) @(negedge i_mclk);
        chk(9'(o_teardown), 9'h001);
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    // random stalls and modem noise
    always @(negedge i_mclk) begin
        lf = nxt(lf);
        {i_net_ready, i_cts, i_dcd, i_sess_count, i_dir_ms} = {lf[0] | lf[1], lf[20:2]};
    end
    always @(posedge i_mclk) if (o_net_valid && i_net_ready) q.push_back({o_net_last, o_net_data});
    initial begin
        lf = 32'h41b1;
        {i_rst, i_ce, i_eight_bits, i_fwd_term, i_net_ready, i_cts, i_dcd} = 7'h7f;
        {i_two_stop, i_four_wire, i_sess_open, i_tx_valid, go, i_dsr, b} = 14'h0000;
        {i_parity, i_flow, i_conn_ctl, i_disc_sel, i_sess_id} = {4'h0, SPB_CC_DTR_DN, 6'h00};
        {i_baud_sel, i_sess_max, i_term_char, i_pkt_len} = {4'hb, 3'h5, 8'h0d, 11'h004};
        // buffering interval far above one character time
        {i_buf_ms, i_idle_sec, i_tx_data, i_sess_count, i_dir_ms} = {16'hffff, 41'h0};
        repeat (8) @(negedge i_mclk);
        i_rst = 1'b0;
        @(negedge i_mclk);
        i_sess_open = 1'b1;
        repeat (2) @(negedge i_mclk);
        chk(9'(o_dtr), 9'h000);
        tx_byte(8'h00, 1'b1);
        tx_byte(8'hff, 1'b1);
        tx_byte(lf[7:0], 1'b1);
        tx_byte(8'ha5, 1'b0);
        // bit 3 cleared so no byte equals the terminator
        for (int k = 0; k < 4; k++) rx_byte(lf[7:0] & 8'hf7);
        pkt(4);
        rx_byte(8'h31);
        rx_byte(8'h32);
        rx_byte(8'h0d);
        pkt(3);
        i_disc_sel = 3'h3;
        @(negedge i_mclk);
        i_dsr = 1'b1;
        wait_td(20);
        i_disc_sel = 3'h0;
        i_idle_sec = 16'h0002;
        wait_td(3000);
        results;
    end
    initial begin
        #1000000;
        num_errors++;
        results;
    end
endmodule
`default_nettype wire
